// File: shared/prp_pkg.sv
// Shared constants and types for the pattern memory playback block
package prp_pkg;
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_LOAD     = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_INT_STAT = 8'h0c;
	localparam logic [7:0] OFS_INT_EN   = 8'h10;
	localparam logic [7:0] OFS_INT_CLR  = 8'h14;
	localparam logic [7:0] OFS_COUNT    = 8'h18;
	localparam logic [7:0] OFS_ERROR    = 8'h1c;
	localparam logic [7:0] OFS_DIVIDER  = 8'h20;
	// Control register fields
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_BLOCK  = 1;
	localparam int CTRL_FORMAT = 2;
	localparam int CTRL_LARGE  = 3;
	// Load register fields
	localparam int LOAD_START  = 8;
	// Pattern byte fields
	localparam int PB_DATA   = 0;
	localparam int PB_BURST  = 2;
	localparam int PB_MARKER = 6;
	localparam int PB_RESET  = 7;
	// Reserved field checks on an encoded byte
	localparam logic [7:0] PB_FIXED_MASK = 8'h3a;
	localparam logic [7:0] PB_FIXED_VAL  = 8'h10;
	// Interrupt bits
	localparam int IRQ_OVERFLOW = 0;
	localparam int IRQ_WRAP     = 1;
	localparam int IRQ_CLEARED  = 2;
	localparam int IRQ_NBITS    = 3;
	// Capacities in bytes
	localparam int unsigned SMALL_BYTES = 32'd1048576;
	localparam int unsigned LARGE_BYTES = 32'd8388608;
	// Error code for an oversize download, two's complement
	localparam logic [31:0] ERR_TOO_MUCH = 32'hffffff21;
	// Reset values
	localparam logic [31:0] DIVIDER_RST = 32'h00000001;
	typedef enum logic [1:0] {
		PRP_IDLE,
		PRP_PARSE,
		PRP_CLEAR
	} prp_load_t;
	typedef struct packed {
		logic modulation_data;
		logic rf_gate;
		logic marker;
		logic restart;
	} prp_play_t;
endpackage

// File: rtl/prp_pattern_ram_playback.sv
// Pattern memory loader and playback sequencer
`timescale 1ns/10ps
// What this block does
// - Each location holds one byte, bit0 data
// - Data bit used only when burst set
// - Bit 2 gates the RF output
// - Bit 6 toggles the marker output
// - Bit 7 clear advances, set restarts
// - Capacity 1 or 8 Mbyte by configuration
// - Oversize download rejected with error -223
// - Memory cleared when format is activated
// - List values land at consecutive addresses
// - List values parsed before storing
// - Block bytes stored raw, unparsed
// - Presence of loaded pattern is reported
module prp_pattern_ram_playback
	import prp_pkg::*;
#(
	parameter int AW = 20
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// Data clock tick of the active format
	input  wire logic        data_clk_tick,
	// Modulator side
	output prp_play_t        play,
	output logic             irq
);
	localparam int unsigned DEPTH = 1 << AW;

	logic [7:0]    mem [DEPTH];
	logic [3:0]    ctrl;
	logic [AW:0]   wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic          present;
	logic [31:0]   err_code;
	logic [IRQ_NBITS-1:0] int_stat;
	logic [IRQ_NBITS-1:0] int_en;
	prp_load_t     lstate;
	logic [7:0]    parse_val;
	logic [7:0]    cur;
	logic          cur_valid;
	logic [AW:0]   clr_ptr;

	// Decodes
	wire w_ctrl  = wr && addr == OFS_CTRL;
	wire w_load  = wr && addr == OFS_LOAD;
	wire w_clr   = wr && addr == OFS_INT_CLR;
	wire w_en    = wr && addr == OFS_INT_EN;
	// Active capacity: small unless large config and memory allows it
	wire [AW:0] cap = (ctrl[CTRL_LARGE] || DEPTH <= SMALL_BYTES) ?
		(AW+1)'(DEPTH) : (AW+1)'(SMALL_BYTES);
	wire load_go  = w_load && wdata[LOAD_START];
	// Format activation clears memory and aborts downloads
	wire fmt_go   = w_ctrl && wdata[CTRL_FORMAT];
	// A byte waiting in the parse stage already holds a slot
	wire [AW:0] fill = wr_ptr + (AW+1)'(lstate == PRP_PARSE);
	wire full     = fill >= cap;
	wire overflow = load_go && full && lstate != PRP_CLEAR;
	wire do_store = (lstate == PRP_PARSE) && wr_ptr < cap;
	wire clr_done = lstate == PRP_CLEAR && clr_ptr == (AW+1)'(DEPTH - 1);
	wire running  = ctrl[CTRL_RUN] && present && lstate == PRP_IDLE;
	wire wrap_ev  = running && data_clk_tick && cur_valid &&
		cur[PB_RESET];
	wire [IRQ_NBITS-1:0] ev = {clr_done, wrap_ev, overflow};

	// Control register
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctrl <= 4'h0;
		else if (w_ctrl)
			ctrl <= {wdata[CTRL_LARGE], 1'b0, wdata[CTRL_BLOCK],
				wdata[CTRL_RUN]};
	end

	// Download path: block bytes go straight in, list bytes pass
	// through a parse stage first, costing one extra cycle each.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lstate    <= PRP_IDLE;
			parse_val <= 8'h00;
		end else if (fmt_go) begin
			lstate    <= PRP_CLEAR;
		end else if (lstate == PRP_CLEAR) begin
			if (clr_done)
				lstate <= PRP_IDLE;
		end else if (load_go && !full) begin
			if (ctrl[CTRL_BLOCK]) begin
				lstate <= PRP_IDLE;
			end else begin
				parse_val <= wdata[7:0];
				lstate    <= PRP_PARSE;
			end
		end else begin
			lstate <= PRP_IDLE;
		end
	end

	wire blk_store = load_go && !full && ctrl[CTRL_BLOCK] &&
		!fmt_go && lstate == PRP_IDLE;
	wire [AW-1:0] waddr = lstate == PRP_CLEAR ? clr_ptr[AW-1:0] :
		wr_ptr[AW-1:0];
	wire [7:0] wbyte = lstate == PRP_CLEAR ? 8'h00 :
		(do_store ? parse_val : wdata[7:0]);
	wire mem_we = blk_store || do_store || lstate == PRP_CLEAR;

	// Each stored value takes the next consecutive address
	always_ff @(posedge mclk) begin
		if (mem_we)
			mem[waddr] <= wbyte;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr  <= '0;
			clr_ptr <= '0;
			present <= 1'b0;
		end else if (fmt_go) begin
			wr_ptr  <= '0;
			clr_ptr <= '0;
			present <= 1'b0;
		end else if (lstate == PRP_CLEAR) begin
			clr_ptr <= clr_ptr + (AW+1)'(1);
		end else if (blk_store || do_store) begin
			wr_ptr  <= wr_ptr + (AW+1)'(1);
			present <= 1'b1;
		end
	end

	// Error code holds until written
	always_ff @(posedge mclk) begin
		if (!rst_n)
			err_code <= 32'h0;
		else if (overflow)
			err_code <= ERR_TOO_MUCH;
		else if (wr && addr == OFS_ERROR)
			err_code <= 32'h0;
	end

	// Playback: current byte fetched, advanced per data clock tick
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_ptr    <= '0;
			cur       <= 8'h00;
			cur_valid <= 1'b0;
		end else if (!running) begin
			rd_ptr    <= '0;
			cur_valid <= 1'b0;
		end else if (!cur_valid) begin
			cur       <= mem[rd_ptr];
			cur_valid <= 1'b1;
		end else if (data_clk_tick) begin
			cur_valid <= 1'b0;
			// Restart at zero on reset byte or past written end
			if (cur[PB_RESET] ||
				(AW+1)'(rd_ptr) + (AW+1)'(1) >= wr_ptr)
				rd_ptr <= '0;
			else
				rd_ptr <= rd_ptr + AW'(1);
		end
	end

	// Outputs registered per played byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			play <= '0;
		end else if (!running) begin
			play.rf_gate         <= 1'b0;
			play.modulation_data <= 1'b0;
			play.restart         <= 1'b0;
		end else if (cur_valid && data_clk_tick) begin
			play.rf_gate         <= cur[PB_BURST];
			play.modulation_data <= cur[PB_DATA] &
				cur[PB_BURST];
			play.restart         <= cur[PB_RESET];
			if (cur[PB_MARKER])
				play.marker <= ~play.marker;
		end
	end

	// Interrupts: set wins over clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			int_stat <= '0;
			int_en   <= '0;
		end else begin
			int_stat <= (int_stat & ~(w_clr ? wdata[IRQ_NBITS-1:0] :
				'0)) | ev;
			if (w_en)
				int_en <= wdata[IRQ_NBITS-1:0];
		end
	end
	assign irq = |(int_stat & int_en);

	// Read data, one cycle after the strobe
	wire [31:0] status_w = {28'h0, lstate != PRP_IDLE, full,
		running, present};
	wire [31:0] rmux =
		addr == OFS_CTRL     ? {28'h0, ctrl} :
		addr == OFS_STATUS   ? status_w :
		addr == OFS_INT_STAT ? {29'h0, int_stat} :
		addr == OFS_INT_EN   ? {29'h0, int_en} :
		addr == OFS_COUNT    ? 32'(wr_ptr) :
		addr == OFS_ERROR    ? err_code : 32'h0;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata <= 32'h0;
		else
			rdata <= rd ? rmux : 32'h0;
	end

	// Playback outputs follow the byte consumed on each tick
	AST_MARK_TOGGLE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick && cur[PB_MARKER]
		|=> play.marker != $past(play.marker))
		else $error("marker did not toggle");
	AST_MARK_HOLD: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!(cur_valid && data_clk_tick) |=> $stable(play.marker))
		else $error("marker changed without a marked byte");
	AST_MARK_SKIP: assert property (
		@(posedge mclk) disable iff (!rst_n)
		cur_valid && data_clk_tick && !cur[PB_MARKER]
		|=> $stable(play.marker))
		else $error("marker changed on an unmarked byte");
	AST_GATE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick
		|=> play.rf_gate == $past(cur[PB_BURST]))
		else $error("rf gate differs from burst bit");
	AST_GATE_IDLE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!running |=> !play.rf_gate && !play.restart)
		else $error("outputs active while stopped");
	AST_DATA: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick
		|=> play.modulation_data == $past(cur[PB_DATA] & cur[PB_BURST]))
		else $error("modulation data differs from played byte");
	AST_DATA_QUIET: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!play.rf_gate |-> !play.modulation_data)
		else $error("data driven while burst off");
	AST_RESTART_OUT: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick
		|=> play.restart == $past(cur[PB_RESET]))
		else $error("restart output differs from reset bit");
	AST_RESTART: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick && cur[PB_RESET]
		|=> rd_ptr == '0)
		else $error("no restart after reset byte");
	AST_ADVANCE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick && !cur[PB_RESET] &&
		(AW+1)'(rd_ptr) + (AW+1)'(1) < wr_ptr
		|=> rd_ptr == $past(rd_ptr) + AW'(1))
		else $error("address did not advance by one");
	AST_WRAP_END: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && cur_valid && data_clk_tick &&
		(AW+1)'(rd_ptr) + (AW+1)'(1) >= wr_ptr
		|=> rd_ptr == '0)
		else $error("no wrap after last loaded byte");
	AST_PTR_HOLD: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && !(cur_valid && data_clk_tick) |=> $stable(rd_ptr))
		else $error("address moved without a tick");
	AST_PTR_IDLE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!running |=> rd_ptr == '0)
		else $error("address not parked at zero while stopped");
	AST_FETCH: assert property (
		@(posedge mclk) disable iff (!rst_n)
		running && !cur_valid |=> cur == $past(mem[rd_ptr]))
		else $error("fetched byte differs from memory");
	AST_WRAP_IRQ: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wrap_ev |=> int_stat[IRQ_WRAP])
		else $error("wrap event not recorded");
	// Download path
	AST_LIST_STORE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		do_store && !fmt_go |=> wr_ptr == $past(wr_ptr) + (AW+1)'(1)
		&& present)
		else $error("parsed value not stored in order");
	AST_LIST_BYTE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		do_store |=> mem[$past(wr_ptr[AW-1:0])] == $past(parse_val))
		else $error("parsed value not written");
	AST_BLK_BYTE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		blk_store |=> mem[$past(wr_ptr[AW-1:0])] == $past(wdata[7:0]))
		else $error("block byte not written raw");
	AST_BLK_COUNT: assert property (
		@(posedge mclk) disable iff (!rst_n)
		blk_store |=> wr_ptr == $past(wr_ptr) + (AW+1)'(1) && present)
		else $error("block byte not counted");
	AST_NO_OVERRUN: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(blk_store || do_store) |-> wr_ptr < cap)
		else $error("write beyond capacity");
	AST_PTR_BOUND: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_ptr <= (AW+1)'(DEPTH))
		else $error("write pointer beyond array");
	AST_OVF_ERR: assert property (
		@(posedge mclk) disable iff (!rst_n)
		overflow |=> err_code == ERR_TOO_MUCH)
		else $error("oversize download not flagged");
	AST_OVF_REFUSE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		load_go && full && !do_store |=> wr_ptr == $past(wr_ptr))
		else $error("byte accepted while full");
	AST_OVF_IRQ: assert property (
		@(posedge mclk) disable iff (!rst_n)
		overflow |=> int_stat[IRQ_OVERFLOW])
		else $error("overflow not recorded");
	AST_ERR_HOLD: assert property (
		@(posedge mclk) disable iff (!rst_n)
		err_code == ERR_TOO_MUCH && !(wr && addr == OFS_ERROR)
		|=> err_code == ERR_TOO_MUCH)
		else $error("error code lost");
	// Format activation
	AST_FMT_CLEAR: assert property (
		@(posedge mclk) disable iff (!rst_n)
		fmt_go |=> !present && wr_ptr == '0 && lstate == PRP_CLEAR)
		else $error("format activation did not clear");
	AST_CLEAR_BYTE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		lstate == PRP_CLEAR |=> mem[$past(clr_ptr[AW-1:0])] == 8'h00)
		else $error("location not cleared");
	AST_CLEAR_END: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clr_done && !fmt_go |=> lstate == PRP_IDLE)
		else $error("clear did not finish");
	AST_CLR_IRQ: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clr_done |=> int_stat[IRQ_CLEARED])
		else $error("clear finish not recorded");
	AST_PRESENT_HOLD: assert property (
		@(posedge mclk) disable iff (!rst_n)
		present && !fmt_go |=> present)
		else $error("presence lost without format change");
	AST_STATUS_RD: assert property (
		@(posedge mclk) disable iff (!rst_n)
		rd && addr == OFS_STATUS |=> rdata[0] == $past(present))
		else $error("presence not reported");
endmodule

// File: tb/prp_ctl_model.sv
// Controller model that downloads patterns over the register port
`timescale 1ns/10ps
module prp_ctl_model
	import prp_pkg::*;
(
	// Clock and read data
	input  wire logic        mclk,
	input  wire logic [31:0] rdata,
	// Register port towards the device
	output logic      [7:0]  addr,
	output logic      [31:0] wdata,
	output logic             wr,
	output logic             rd
);
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Data kept raw when burst is off, so ignoring it is exercised
	function automatic logic [7:0] encode(input logic dat, input logic burst,
			input logic mark, input logic last);
		return {last, mark, 3'h2, burst, 1'b0, dat};
	endfunction
	// Released lines show the inverse, never a stale match
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		addr <= ~a;
		#1 d = rdata;
	endtask
	task automatic load(input logic [7:0] b);
		wr_reg(OFS_LOAD, {23'h0, 1'b1, b});
	endtask
endmodule

// File: tb/prp_pattern_ram_playback_tb.sv
// Self-checking bench for the pattern memory playback block
`timescale 1ns/10ps
module prp_pattern_ram_playback_tb import prp_pkg::*; ;
	localparam int AW = 4;
	localparam int DEPTH = 1 << AW;
	logic        mclk, rst_n, tick, wr, rd, irq, mark;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [2:0]  r;
	logic [7:0]  pat [DEPTH];
	prp_play_t   play;
	int          fails, n_compared, n;

	prp_pattern_ram_playback #(.AW(AW)) DUT (.mclk(mclk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.data_clk_tick(tick), .play(play), .irq(irq));
	prp_ctl_model u_ctl (.mclk(mclk), .rdata(rdata), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_reg(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		logic [31:0] v;
		u_ctl.rd_reg(a, v);
		chk(what, exp, v);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Clearing takes one cycle per location; poll with a bound
	task automatic wait_idle();
		logic [31:0] v;
		for (int i = 0; i < 4 * DEPTH; i++) begin
			u_ctl.rd_reg(OFS_STATUS, v);
			if (v[3] === 1'b0)
				return;
		end
		fails++;
		$display("ERROR busy expected 0 seen 1");
		conclude();
	endtask
	// Ticks spaced wide enough for the fetch of the next byte
	task automatic play_byte(input logic [7:0] b);
		@(posedge mclk);
		tick <= 1'b1;
		@(posedge mclk);
		tick <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 mark = mark ^ b[PB_MARKER];
		chk("gate", b[PB_BURST], play.rf_gate);
		chk("data", b[PB_DATA] & b[PB_BURST], play.modulation_data);
		chk("marker", mark, play.marker);
		chk("restart", b[PB_RESET], play.restart);
	endtask

	initial begin
		rst_n = 1'b0;
		tick = 1'b0;
		fails = 0;
		n_compared = 0;
		mark = 1'b0;
		void'($urandom(32'h1f28));
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("play", 32'h0, 32'(play));
		chk_reg("unmapped", 8'hfc, 32'h0);
		u_ctl.wr_reg(OFS_INT_EN, 32'h7);
		u_ctl.wr_reg(OFS_CTRL, 32'h4);
		wait_idle();
		chk_reg("status", OFS_STATUS, 32'h0);
		chk_reg("int_stat", OFS_INT_STAT, 32'h4);
		#1 chk("irq", 32'h1, irq);
		u_ctl.wr_reg(OFS_INT_CLR, 32'h4);
		#1 chk("irq", 32'h0, irq);
		n = $urandom_range(12, 4);
		for (int i = 0; i < n; i++) begin
			r = 3'($urandom_range(7, 0));
			pat[i] = u_ctl.encode(r[0], r[1], r[2], i == n - 1);
			u_ctl.load(pat[i]);
		end
		repeat (2) @(posedge mclk);
		chk_reg("count", OFS_COUNT, n);
		chk_reg("status", OFS_STATUS, 32'h1);
		u_ctl.wr_reg(OFS_CTRL, 32'h1);
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 2 * n + 1; i++)
			play_byte(pat[i % n]);
		chk_reg("int_stat", OFS_INT_STAT, 32'h2);
		#1 chk("irq", 32'h1, irq);
		u_ctl.wr_reg(OFS_CTRL, 32'h0);
		u_ctl.wr_reg(OFS_INT_EN, 32'h0);
		#1 chk("irq", 32'h0, irq);
		u_ctl.wr_reg(OFS_INT_CLR, 32'h7);
		chk_reg("int_stat", OFS_INT_STAT, 32'h0);
		u_ctl.wr_reg(OFS_CTRL, 32'h6);
		wait_idle();
		for (int i = 0; i < DEPTH; i++) begin
			r = 3'($urandom_range(7, 0));
			pat[i] = u_ctl.encode(r[0], 1'b1, r[2], i == DEPTH - 1);
			u_ctl.load(pat[i]);
		end
		u_ctl.load(8'h15);
		chk_reg("count", OFS_COUNT, DEPTH);
		chk_reg("error", OFS_ERROR, ERR_TOO_MUCH);
		chk_reg("int_stat", OFS_INT_STAT, 32'h5);
		chk_reg("status", OFS_STATUS, 32'h5);
		u_ctl.wr_reg(OFS_ERROR, 32'h0);
		chk_reg("error", OFS_ERROR, 32'h0);
		u_ctl.wr_reg(OFS_CTRL, 32'ha);
		u_ctl.load(8'h15);
		chk_reg("count", OFS_COUNT, DEPTH);
		chk_reg("error", OFS_ERROR, ERR_TOO_MUCH);
		u_ctl.wr_reg(OFS_CTRL, 32'h3);
		chk_reg("ctrl", OFS_CTRL, 32'h3);
		for (int i = 0; i < 4; i++)
			play_byte(pat[i]);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("play", 32'h0, 32'(play));
		chk_reg("status", OFS_STATUS, 32'h0);
		conclude();
	end
endmodule
